// ### logic/buck_fault_map.svh
// Purpose: register offsets, field positions and reset values of the buck configuration
//          word and the volatile fault status map
// Assumes: 32-bit AXI4-Lite data, one aligned word per register, byte address = 4 * index
// Notes:   fault offsets are register indices, not byte addresses
//
// Operation
// - buck sequencing disable at bit 24 resets to 1; write one clears it.
// - buck current limit at bit 23 resets to 0; 0 is 600 mA, 1 is 150 mA.
// - buck voltage select at bits 22-21 resets to 1; codes 3.3/5.0/4.0/5.7 V.
// - fault map decodes gate driver word at E0h and controller word at E2h.
// - fault map fields are read-only and follow the synchronised fault inputs after reset.
// - gate driver word bit 31 is the OR of fault bits, mirroring fault pin.
`ifndef BUCK_FAULT_MAP_SVH
`define BUCK_FAULT_MAP_SVH

// register indices and the byte address derived from them
`define GATE_FAULT_INDEX     10'h0e0
`define CTRL_FAULT_INDEX     10'h0e2
`define BUCK_CONFIG_INDEX    10'h000
`define BYTE_ADDR(idx)       {(idx), 2'b00}
`define ADDR_WIDTH           12

// buck configuration word fields
`define BUCK_PARITY_BIT      31
`define BUCK_SEQ_DIS_BIT     24
`define BUCK_CURRENT_LIMIT_SELECT_BIT          23
`define BUCK_SEL_HI          22
`define BUCK_SEL_LO          21
`define BUCK_CONFIG_RESET    32'h01200000

// gate driver fault word
`define GATE_SUMMARY_BIT     31
`define FAULT_WORD_RESET     32'h00000000

// bus answers
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10
`define RESP_DECERR          2'b11

`endif

// ### logic/buck_fault_pkg.sv
// Purpose: shared types of the buck configuration and fault map block
// Assumes: constants live in buck_fault_map.svh
// Notes:   none
package buck_fault_pkg;

    // which register an address selects
    typedef enum logic [1:0] {
        sel_buck_config,
        sel_gate_fault,
        sel_ctrl_fault,
        sel_none
    } reg_sel_type;

endpackage

// ### logic/level_sync.sv
// Purpose: two-flop synchroniser for a vector of independent level inputs
// Assumes: each bit is a slow level from outside the clock domain
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
module level_sync #(
    parameter int WIDTH = 32
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] stage_one;

    // one two-flop chain per bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    stage_one[i] <= 1'b0;
                    level_out[i] <= 1'b0;
                end else begin
                    stage_one[i] <= level_in[i];
                    level_out[i] <= stage_one[i];
                end
            end
        end
    endgenerate

endmodule

// ### logic/buck_config_and_fault_map.sv
// Purpose: AXI4-Lite register bank holding the buck regulator configuration word and
//          the read-only gate driver and controller fault status words
// Assumes: fault inputs are asynchronous levels; one write and one read at a time
// Notes:   writes to fault words answer SLVERR, unmapped addresses answer DECERR
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "buck_fault_map.svh"
module buck_config_and_fault_map
    import buck_fault_pkg::*;
(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // write address channel
    input  wire logic [`ADDR_WIDTH-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    // write data channel
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // write response channel
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // read address channel
    input  wire logic [`ADDR_WIDTH-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    // read data channel
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // fault sources and indication
    input  wire logic [30:0]            gate_fault_in,
    input  wire logic [31:0]            controller_fault_in,
    output logic                        fault_indication_pin_n,
    // buck regulator controls
    output logic                        buck_sequencing_disable,
    output logic                        buck_current_limit_select,
    output logic [1:0]                  buck_voltage_select,
    output logic                        buck_parity
);

    // address decode shared by the write and read paths
    function automatic reg_sel_type decode_addr(input logic [`ADDR_WIDTH-1:0] addr);
        if (addr[`ADDR_WIDTH-1:2] == `BUCK_CONFIG_INDEX) begin
            return sel_buck_config;
        end else if (addr[`ADDR_WIDTH-1:2] == `GATE_FAULT_INDEX) begin
            return sel_gate_fault;
        end else if (addr[`ADDR_WIDTH-1:2] == `CTRL_FAULT_INDEX) begin
            return sel_ctrl_fault;
        end else begin
            return sel_none;
        end
    endfunction

    logic [31:0]            buck_regulator_config;
    logic [31:0]            gate_driver_fault_word;
    logic [31:0]            controller_fault_word;
    logic [30:0]            gate_fault_sync;
    logic [31:0]            ctrl_fault_sync;
    logic                   aw_held;
    logic                   w_held;
    logic [`ADDR_WIDTH-1:0] aw_addr;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   do_write;
    reg_sel_type            write_sel;
    reg_sel_type            read_sel;
    logic [31:0]            next_config;

    // both fault sources cross into the clock domain here
    level_sync #(
        .WIDTH(31)
    ) u_gate_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .level_in (gate_fault_in),
        .level_out(gate_fault_sync)
    );

    level_sync #(
        .WIDTH(32)
    ) u_ctrl_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .level_in (controller_fault_in),
        .level_out(ctrl_fault_sync)
    );

    // fault words follow the synchronised sources, no bus path writes them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_driver_fault_word <= `FAULT_WORD_RESET;
            controller_fault_word  <= `FAULT_WORD_RESET;
        end else begin
            gate_driver_fault_word <= {|gate_fault_sync, gate_fault_sync};
            controller_fault_word  <= ctrl_fault_sync;
        end
    end

    // fault pin is driven low while the summary bit is set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_indication_pin_n <= 1'b1;
        end else begin
            fault_indication_pin_n <= ~(|gate_fault_sync);
        end
    end

    // write address and data are taken independently, response after both
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;
    assign write_sel     = decode_addr(aw_addr);

    // capture of the write address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    // capture of the write data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    // byte-lane merge of the configuration word, sequencing bit is write-one-to-clear
    always_comb begin
        next_config = buck_regulator_config;
        for (int b = 0; b < 4; b++) begin
            if (w_strb[b]) begin
                next_config[b*8 +: 8] = w_data[b*8 +: 8];
            end
        end
        next_config[`BUCK_SEQ_DIS_BIT] = buck_regulator_config[`BUCK_SEQ_DIS_BIT]
                                         & ~(w_strb[`BUCK_SEQ_DIS_BIT/8]
                                             & w_data[`BUCK_SEQ_DIS_BIT]);
    end

    // configuration word storage
    // sequencing disable only ever falls here, reset is the one way to raise it again
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buck_regulator_config <= `BUCK_CONFIG_RESET;
        end else if (do_write && write_sel == sel_buck_config) begin
            buck_regulator_config <= next_config;
        end
    end

    // write response: fault words refuse writes, unmapped space is a decode error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            if (write_sel == sel_buck_config) begin
                s_axi_bresp <= `RESP_OKAY;
            end else if (write_sel == sel_none) begin
                s_axi_bresp <= `RESP_DECERR;
            end else begin
                s_axi_bresp <= `RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read path: one outstanding read, data registered one cycle after the address
    assign s_axi_arready = !s_axi_rvalid;
    assign read_sel      = decode_addr(s_axi_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            if (read_sel == sel_buck_config) begin
                s_axi_rdata <= buck_regulator_config;
            end else if (read_sel == sel_gate_fault) begin
                s_axi_rdata <= gate_driver_fault_word;
            end else if (read_sel == sel_ctrl_fault) begin
                s_axi_rdata <= controller_fault_word;
            end else begin
                s_axi_rdata <= '0;
                s_axi_rresp <= `RESP_DECERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // buck controls steered by the configuration word
    assign buck_sequencing_disable   = buck_regulator_config[`BUCK_SEQ_DIS_BIT];
    assign buck_current_limit_select = buck_regulator_config[`BUCK_CURRENT_LIMIT_SELECT_BIT];
    assign buck_voltage_select       = buck_regulator_config[`BUCK_SEL_HI:`BUCK_SEL_LO];
    assign buck_parity               = buck_regulator_config[`BUCK_PARITY_BIT];

endmodule

// ### testbench/buck_fault_checker.sv
// Purpose: assertions on the buck config and fault map ports
// Assumes: one write and one read at a time
// Notes:   fault offsets compared as word indices
`timescale 1ns/1ns
`include "buck_fault_map.svh"
module buck_fault_checker (
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire logic [`ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic                   s_axi_awvalid,
    input wire logic                   s_axi_awready,
    input wire logic                   s_axi_wvalid,
    input wire logic                   s_axi_wready,
    input wire logic [1:0]             s_axi_bresp,
    input wire logic                   s_axi_bvalid,
    input wire logic [`ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic [31:0]            s_axi_rdata,
    input wire logic [1:0]             s_axi_rresp,
    input wire logic                   s_axi_rvalid,
    input wire logic [30:0]            gate_fault_in,
    input wire logic                   fault_indication_pin_n,
    input wire logic                   buck_sequencing_disable,
    input wire logic                   buck_current_limit_select,
    input wire logic [1:0]             buck_voltage_select,
    input wire logic                   buck_parity
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [9:0] aw_q, ar_q;
    wire logic  aw_fault = aw_q == `GATE_FAULT_INDEX || aw_q == `CTRL_FAULT_INDEX;

    // addresses of the write and read under way
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr[11:2];
        if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr[11:2];
    end

    sequence seq_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence seq_read_done;
        $rose(s_axi_rvalid);
    endsequence

    a_reset_values: assert property ($rose(aresetn) |->
        buck_sequencing_disable && !buck_current_limit_select &&
        buck_voltage_select == 2'b01 && !buck_parity)
        else $error("config outputs wrong after reset");
    a_seq_dis_clear: assert property ($rose(buck_sequencing_disable) |-> !$past(aresetn))
        else $error("sequencing disable set without reset");
    a_cfg_write_only: assert property ($changed({buck_parity, buck_sequencing_disable,
        buck_current_limit_select, buck_voltage_select}) |->
        $rose(s_axi_bvalid) || !$past(aresetn))
        else $error("config changed without a write");
    a_write_answer: assert property (seq_both_taken |=> !s_axi_awready ##1 s_axi_bvalid)
        else $error("write answer late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_fault_write_err: assert property ($rose(s_axi_bvalid) && aw_fault |->
        s_axi_bresp == `RESP_SLVERR)
        else $error("fault word write not refused");
    a_fault_read_ok: assert property (seq_read_done and (ar_q == `CTRL_FAULT_INDEX) |->
        s_axi_rresp == `RESP_OKAY)
        else $error("fault word read refused");
    a_summary_or: assert property (seq_read_done and (ar_q == `GATE_FAULT_INDEX) |->
        s_axi_rdata[31] == |s_axi_rdata[30:0] && s_axi_rresp == `RESP_OKAY)
        else $error("summary bit wrong");
    a_pin_low: assert property ((|gate_fault_in) [*3] |=> !fault_indication_pin_n)
        else $error("fault pin not low");
    a_pin_high: assert property ((gate_fault_in == 31'h0) [*3] |=> fault_indication_pin_n)
        else $error("fault pin not high");
endmodule

bind buck_config_and_fault_map buck_fault_checker u_chk (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .gate_fault_in, .fault_indication_pin_n, .buck_sequencing_disable,
    .buck_current_limit_select, .buck_voltage_select, .buck_parity);

// ### testbench/test_buck_config_and_fault_map.sv
// Purpose: self-checking bench for the buck config and fault map
// Assumes: bready and rready held high, answers taken at once
// Notes:   expected config kept in cfg
`timescale 1ns/1ns
`include "buck_fault_map.svh"
module test_buck_config_and_fault_map;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, fault_indication_pin_n, buck_sequencing_disable;
    logic        buck_current_limit_select, buck_parity;
    logic [1:0]  s_axi_bresp, s_axi_rresp, buck_voltage_select;
    logic [3:0]  s_axi_wstrb;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [30:0] gate_fault_in;
    logic [31:0] s_axi_wdata, s_axi_rdata, controller_fault_in, cfg, d;
    int          n_fail, n_compared, cyc;
    localparam logic [11:0] A_CFG  = `BYTE_ADDR(`BUCK_CONFIG_INDEX);
    localparam logic [11:0] A_GATE = `BYTE_ADDR(`GATE_FAULT_INDEX);
    localparam logic [11:0] A_CTRL = `BYTE_ADDR(`CTRL_FAULT_INDEX);

    buck_config_and_fault_map uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gate_fault_in,
        .controller_fault_in, .fault_indication_pin_n, .buck_sequencing_disable,
        .buck_current_limit_select, .buck_voltage_select, .buck_parity);

    // 50 MHz clock
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            results;
        end
    end

    task automatic results;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    // expected config after a write: byte merge, bit 24 only clears
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
                                          input logic [3:0] s);
        logic [31:0] n;
        n = o;
        for (int b = 0; b < 4; b++)
            if (s[b]) n[8*b +: 8] = w[8*b +: 8];
        n[24] = o[24] & ~(s[3] & w[24]);
        return n;
    endfunction

    task automatic rst;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        cfg = `BUCK_CONFIG_RESET;
    endtask

    // one write, address and data offered together
    task automatic wr(input logic [11:0] a, input logic [31:0] w, input logic [3:0] s,
                      input logic [1:0] er);
        logic aw_left, w_left;
        aw_left = 1'b1;
        w_left = 1'b1;
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, w, s};
        {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
        while (aw_left || w_left) begin
            @(posedge aclk);
            if (aw_left && s_axi_awready) begin
                aw_left = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_left && s_axi_wready) begin
                w_left = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        chk("bresp", er, s_axi_bresp);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask

    // write config, then check outputs and read back
    task automatic wcfg(input logic [31:0] w, input logic [3:0] s);
        wr(A_CFG, w, s, `RESP_OKAY);
        cfg = merge(cfg, w, s);
        chk("outs", {cfg[31], cfg[24:21]}, {buck_parity, buck_sequencing_disable,
            buck_current_limit_select, buck_voltage_select});
        rd(A_CFG, cfg, `RESP_OKAY);
    endtask

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, s_axi_wstrb, controller_fault_in, gate_fault_in} = '0;
        {s_axi_bready, s_axi_rready} = 2'b11;
        void'($urandom(96534));
        rst;
        wcfg(32'h0, 4'h0);
        rd(A_GATE, 32'h0, `RESP_OKAY);
        rd(A_CTRL, 32'h0, `RESP_OKAY);
        $display("test reset values done");
        for (int c = 0; c < 4; c++) begin
            d = $urandom() & 32'hfeffffff;
            d[22:21] = c[1:0];
            wcfg(d, 4'h4 | 4'($urandom()));
        end
        wcfg(32'h01000000, 4'h7);
        wcfg(32'h01000000, 4'h8);
        wcfg(32'hffffffff, 4'hf);
        rst;
        wcfg(32'h0, 4'h0);
        $display("test config writes done");
        for (int i = 0; i < 6; i++) begin
            gate_fault_in <= (i < 2) ? 31'(i) : 31'($urandom());
            controller_fault_in <= $urandom();
            repeat (4) @(posedge aclk);
            rd(A_GATE, {|gate_fault_in, gate_fault_in}, `RESP_OKAY);
            rd(A_CTRL, controller_fault_in, `RESP_OKAY);
            chk("pin", ~|gate_fault_in, fault_indication_pin_n);
        end
        $display("test fault words done");
        rst;
        rd(A_GATE, 32'h0, `RESP_OKAY);
        wr(A_GATE, 32'hffffffff, 4'hf, `RESP_SLVERR);
        wr(A_CTRL, 32'hffffffff, 4'hf, `RESP_SLVERR);
        rd(A_GATE, {|gate_fault_in, gate_fault_in}, `RESP_OKAY);
        rd(A_CTRL, controller_fault_in, `RESP_OKAY);
        wr(12'h004, $urandom(), 4'hf, `RESP_DECERR);
        rd(12'h004, 32'h0, `RESP_DECERR);
        rd(12'h384, 32'h0, `RESP_DECERR);
        rd(A_CFG, cfg, `RESP_OKAY);
        $display("test refusals done");
        results;
    end
endmodule
